// [logic/slms_top.v]
// Link and mode set-up for the camera-side serializer with an APB register port.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "slms_defines.vh"

module slms_top #(
    parameter FULL_FEATURE = 1
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pins
    input  wire [2:0]  strap_config_level,
    input  wire        power_down_pin_n,
    output reg         lock_indicator_pin,
    output reg         error_out_pin_n,
    // Serial link PHY
    input  wire        phy_locked,
    output reg         link_reset,
    output reg         link_train_start,
    output reg  [1:0]  link_rate_sel,
    output reg         link_coax,
    output reg         link_tunnel,
    // Video path feature controls
    output reg         passthrough_en,
    output reg         e2e_crc_en,
    output reg         vc_remap_allow,
    output reg         long_line_allow,
    output reg         video_line_check,
    output reg         packet_check_opt,
    output reg  [31:0] rev_rate_kbps
);

    localparam ST_HOLD  = 3'b001;
    localparam ST_TRAIN = 3'b010;
    localparam ST_LOCK  = 3'b100;

    // ============================================================
    // Pin synchronisers
    wire [4:0] sync_out;
    wire [2:0] strap_s   = sync_out[2:0];
    wire       pwr_up_s  = sync_out[3];
    wire       locked_s  = sync_out[4];

    slms_sync2 #(.W(5)) u_sync (
        .clk  (pclk),
        .rst_n(presetn),
        .din  ({phy_locked, power_down_pin_n, strap_config_level}),
        .dout (sync_out)
    );

    // ============================================================
    // State
    reg [1:0] settle_cnt;
    reg       strap_taken;
    reg [2:0] strap_val;
    reg [1:0] rate;
    reg       coax;
    reg       tunnel;
    reg       rst_bit;
    reg       oneshot;
    reg       vc_remap;
    reg       line_chk;
    reg       pkt_chk;
    reg       lockpin_en;
    reg       cfg_err;
    reg [2:0] state;
    reg [2:0] next_state;

    wire apb_wr  = psel & penable & pwrite & pready;
    wire wr_ctrl = apb_wr && (paddr == `SLMS_OFF_CTRL);
    wire wr_stat = apb_wr && (paddr == `SLMS_OFF_STATUS);
    wire [1:0] wr_rate = pwdata[`SLMS_CTRL_RATE_HI:`SLMS_CTRL_RATE_LO];

    wire strap_6g  = strap_s[0];
    wire strap_ok  = (FULL_FEATURE != 0) || !strap_6g;
    wire rate_ok   = (wr_rate == `SLMS_RATE_3G) ||
                     ((wr_rate == `SLMS_RATE_6G) && (FULL_FEATURE != 0));
    wire take_now  = !strap_taken && pwr_up_s && (settle_cnt == `SLMS_STRAP_SETTLE);
    wire link_hold = rst_bit | oneshot | !strap_taken;
    wire err_set   = (take_now && !strap_ok) || (wr_ctrl && !rate_ok);

    // ============================================================
    // Strap capture and configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt  <= 2'h0;
            strap_taken <= 1'b0;
            strap_val   <= 3'h0;
            rate        <= `SLMS_RATE_3G;
            coax        <= 1'b0;
            tunnel      <= 1'b1;
            rst_bit     <= 1'b0;
            oneshot     <= 1'b0;
            vc_remap    <= 1'b0;
            line_chk    <= `SLMS_LINECHK_RST;
            pkt_chk     <= `SLMS_PKTCHK_RST;
            lockpin_en  <= `SLMS_LOCKPIN_RST;
            cfg_err     <= 1'b0;
        end else if (!pwr_up_s) begin
            // Power-down acts as a power cycle: the strap is taken again on wake.
            settle_cnt  <= 2'h0;
            strap_taken <= 1'b0;
            rst_bit     <= 1'b0;
            oneshot     <= 1'b0;
            vc_remap    <= 1'b0;
            line_chk    <= `SLMS_LINECHK_RST;
            pkt_chk     <= `SLMS_PKTCHK_RST;
            lockpin_en  <= `SLMS_LOCKPIN_RST;
            cfg_err     <= 1'b0;
        end else begin
            if (settle_cnt != `SLMS_STRAP_SETTLE) begin
                settle_cnt <= settle_cnt + 2'h1;
            end
            if (take_now) begin
                strap_taken <= 1'b1;
                strap_val   <= strap_s;
                coax        <= strap_s[2];
                tunnel      <= !strap_s[1];
                rate        <= (strap_6g && strap_ok) ? `SLMS_RATE_6G : `SLMS_RATE_3G;
            end
            oneshot <= 1'b0;
            if (wr_ctrl) begin
                if (rate_ok) begin
                    rate <= wr_rate;
                end
                coax       <= pwdata[`SLMS_CTRL_COAX];
                tunnel     <= pwdata[`SLMS_CTRL_TUNNEL];
                rst_bit    <= pwdata[`SLMS_CTRL_LINKRST];
                oneshot    <= pwdata[`SLMS_CTRL_ONESHOT];
                vc_remap   <= pwdata[`SLMS_CTRL_VCREMAP];
                line_chk   <= pwdata[`SLMS_CTRL_LINECHK];
                pkt_chk    <= pwdata[`SLMS_CTRL_PKTCHK];
                lockpin_en <= pwdata[`SLMS_CTRL_LOCKPIN];
            end
            // A new rejection in the clearing cycle wins over the clear.
            if (err_set) begin
                cfg_err <= 1'b1;
            end else if (wr_stat && pwdata[`SLMS_STAT_ERR]) begin
                cfg_err <= 1'b0;
            end
        end
    end

    // ============================================================
    // Link training sequencer
    always @* begin
        next_state = state;
        case (state)
            // Hold is left only after the synchronised lock has dropped, so a stale lock is never reused.
            ST_HOLD:  if (!link_hold && !locked_s) next_state = ST_TRAIN;
            ST_TRAIN: if (link_hold) next_state = ST_HOLD;
                      else if (locked_s) next_state = ST_LOCK;
            ST_LOCK:  if (link_hold) next_state = ST_HOLD;
                      else if (!locked_s) next_state = ST_TRAIN;
            default:  next_state = ST_HOLD;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= ST_HOLD;
            link_train_start   <= 1'b0;
            link_reset         <= 1'b1;
            link_rate_sel      <= `SLMS_RATE_3G;
            link_coax          <= 1'b0;
            link_tunnel        <= 1'b1;
            lock_indicator_pin <= 1'b0;
            error_out_pin_n    <= 1'b1;
            passthrough_en     <= 1'b1;
            e2e_crc_en         <= 1'b1;
            vc_remap_allow     <= 1'b0;
            long_line_allow    <= 1'b1;
            video_line_check   <= `SLMS_LINECHK_RST;
            packet_check_opt   <= `SLMS_PKTCHK_RST;
            rev_rate_kbps      <= `SLMS_REV_RATE_KBPS;
        end else begin
            state              <= next_state;
            link_train_start   <= (state == ST_HOLD) && (next_state == ST_TRAIN);
            link_reset         <= (next_state == ST_HOLD);
            link_rate_sel      <= rate;
            link_coax          <= coax;
            link_tunnel        <= tunnel;
            lock_indicator_pin <= lockpin_en && (state == ST_LOCK);
            error_out_pin_n    <= !cfg_err;
            passthrough_en     <= tunnel;
            e2e_crc_en         <= tunnel;
            vc_remap_allow     <= !tunnel && vc_remap;
            long_line_allow    <= tunnel;
            video_line_check   <= line_chk;
            packet_check_opt   <= pkt_chk;
            rev_rate_kbps      <= `SLMS_REV_RATE_KBPS;
        end
    end

    // ============================================================
    // APB slave: one access cycle, registered answer
    reg [31:0] rd_mux;
    reg        addr_bad;

    always @* begin
        rd_mux   = 32'h0;
        addr_bad = 1'b0;
        case (paddr)
            `SLMS_OFF_CTRL: begin
                rd_mux[`SLMS_CTRL_RATE_HI:`SLMS_CTRL_RATE_LO] = rate;
                rd_mux[`SLMS_CTRL_COAX]    = coax;
                rd_mux[`SLMS_CTRL_TUNNEL]  = tunnel;
                rd_mux[`SLMS_CTRL_LINKRST] = rst_bit;
                rd_mux[`SLMS_CTRL_VCREMAP] = vc_remap;
                rd_mux[`SLMS_CTRL_LINECHK] = line_chk;
                rd_mux[`SLMS_CTRL_PKTCHK]  = pkt_chk;
                rd_mux[`SLMS_CTRL_LOCKPIN] = lockpin_en;
            end
            `SLMS_OFF_STATUS: begin
                rd_mux[`SLMS_STAT_LOCK]  = (state == ST_LOCK);
                rd_mux[`SLMS_STAT_TRAIN] = (state == ST_TRAIN);
                rd_mux[`SLMS_STAT_ERR]   = cfg_err;
                rd_mux[`SLMS_STAT_STRAP_HI:`SLMS_STAT_STRAP_LO] = strap_val;
                rd_mux[`SLMS_STAT_FULL]  = (FULL_FEATURE != 0);
                rd_mux[`SLMS_STAT_TAKEN] = strap_taken;
            end
            `SLMS_OFF_REVRATE: rd_mux = `SLMS_REV_RATE_KBPS;
            default: addr_bad = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & addr_bad;
            if (psel & ~penable & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

endmodule // slms_top

`default_nettype wire

// [pkg/slms_defines.vh]
// Constants for the serializer link and mode set-up block.
`ifndef SLMS_DEFINES_VH
`define SLMS_DEFINES_VH

// ============================================================
// Register byte offsets
`define SLMS_OFF_CTRL       12'h000
`define SLMS_OFF_STATUS     12'h004
`define SLMS_OFF_REVRATE    12'h008

// ============================================================
// Control register fields
`define SLMS_CTRL_RATE_LO   2
`define SLMS_CTRL_RATE_HI   3
`define SLMS_CTRL_COAX      4
`define SLMS_CTRL_TUNNEL    5
`define SLMS_CTRL_LINKRST   6
`define SLMS_CTRL_ONESHOT   7
`define SLMS_CTRL_VCREMAP   8
`define SLMS_CTRL_LINECHK   9
`define SLMS_CTRL_PKTCHK    10
`define SLMS_CTRL_LOCKPIN   11

// ============================================================
// Status register fields
`define SLMS_STAT_LOCK      0
`define SLMS_STAT_TRAIN     1
`define SLMS_STAT_ERR       2
`define SLMS_STAT_STRAP_LO  3
`define SLMS_STAT_STRAP_HI  5
`define SLMS_STAT_FULL      6
`define SLMS_STAT_TAKEN     7

// ============================================================
// Encodings and reset values
`define SLMS_RATE_3G        2'h1
`define SLMS_RATE_6G        2'h2
`define SLMS_LINECHK_RST    1'h1
`define SLMS_PKTCHK_RST     1'h0
`define SLMS_LOCKPIN_RST    1'h1

// Reverse channel rate in kbit/s (187.5 Mbit/s).
`define SLMS_REV_RATE_KBPS  32'h0002dc6c

// Clock edges with the synchronised power-down pin high before the strap is sampled.
`define SLMS_STRAP_SETTLE   2'h3

`endif

// [logic/slms_sync2.v]
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none

module slms_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Levels
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

    reg [W-1:0] meta;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule // slms_sync2

`default_nettype wire

// [verif/slms_monitor.sv]
// Concurrent checks on the ports of the link and mode set-up block.
`timescale 1ns/100ps
`default_nettype none
module slms_monitor #(
    parameter FULL_FEATURE = 1
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        phy_locked,
    input wire logic        lock_indicator_pin,
    input wire logic        link_reset,
    input wire logic        link_train_start,
    input wire logic [1:0]  link_rate_sel,
    input wire logic        link_tunnel,
    input wire logic        passthrough_en,
    input wire logic        e2e_crc_en,
    input wire logic        long_line_allow,
    input wire logic        vc_remap_allow,
    input wire logic [31:0] rev_rate_kbps
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_leave; $fell(link_reset); endsequence
    sequence s_train; ##[0:2] link_train_start; endsequence
    property p_rev; rev_rate_kbps == 32'h0002dc6c; endproperty
    property p_tun; passthrough_en == link_tunnel && e2e_crc_en == link_tunnel; endproperty
    property p_vc; vc_remap_allow |-> !link_tunnel; endproperty
    property p_long; long_line_allow == link_tunnel; endproperty
    property p_rate; link_rate_sel == 2'h1 || link_rate_sel == 2'h2; endproperty
    property p_red; (FULL_FEATURE == 0) |-> link_rate_sel == 2'h1; endproperty
    property p_hold; $rose(link_reset) |-> ##[1:3] !lock_indicator_pin; endproperty
    property p_train; s_leave |-> s_train; endproperty
    property p_lock; $rose(lock_indicator_pin) |-> $past(phy_locked, 2); endproperty
    a_rev: assert property (p_rev) else $error("reverse rate wrong");
    a_tun: assert property (p_tun) else $error("tunnel features wrong");
    a_vc: assert property (p_vc) else $error("remap in tunnel mode");
    a_long: assert property (p_long) else $error("long line permission wrong");
    a_rate: assert property (p_rate) else $error("illegal rate code");
    a_red: assert property (p_red) else $error("reduced variant above 3G");
    a_hold: assert property (p_hold) else $error("lock kept in link reset");
    a_train: assert property (p_train) else $error("no training after reset");
    a_lock: assert property (p_lock) else $error("lock pin without phy lock");
endmodule // slms_monitor
bind slms_top slms_monitor #(.FULL_FEATURE(FULL_FEATURE)) u_mon (.*);
`default_nettype wire

// [verif/slms_link_partner.sv]
// Far-end deserializer model that locks after training when its mode matches.
`timescale 1ns/100ps
`default_nettype none
module slms_link_partner (
    input wire logic  pclk,
    input wire logic  presetn,
    input wire logic  link_reset,
    input wire logic  link_train_start,
    input wire logic  link_tunnel,
    input wire logic  des_tunnel,
    input wire logic  slow,
    output var logic  phy_locked
);
    integer cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || link_reset) begin
            phy_locked <= 1'b0;
            cnt <= 0;
        end else if (link_train_start && link_tunnel == des_tunnel) begin
            cnt <= slow ? 12 : 2;
        end else if (cnt == 1) begin
            phy_locked <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // slms_link_partner
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the link and mode set-up block.
`timescale 1ns/100ps
`default_nettype none
`include "slms_defines.vh"
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic power_down_pin_n = 1, des_tunnel = 1, slow = 0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rev_rate_kbps, rd, w;
    logic [2:0] strap_config_level = 3'h0;
    logic [1:0] link_rate_sel;
    logic pready, pslverr, lock_indicator_pin, error_out_pin_n, phy_locked, link_reset;
    logic link_train_start, link_coax, link_tunnel, passthrough_en, e2e_crc_en;
    logic vc_remap_allow, long_line_allow, video_line_check, packet_check_opt;
    integer fails = 0, checks_done = 0, seed = 40119, i, n;
    always #5 pclk = ~pclk;
    slms_top uut (.*);
    slms_link_partner u_far (.*);
    function automatic logic [3:0] mode_of(input logic [2:0] s);
        return {s[0], !s[0], s[2], !s[1]};
    endfunction
    function automatic logic [9:0] exp_ctrl(input logic [31:0] c);
        return {c[3:2], c[4], {4{c[5]}}, c[8] & !c[5], c[9], c[10]};
    endfunction
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task bound_chk;
        if (n >= 40) begin
            fails++;
            give_verdict;
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        bound_chk;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_for(input logic lock);
        n = 0;
        while ((lock ? lock_indicator_pin : link_train_start) !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        bound_chk;
    endtask
    task pwr_cycle(input logic [2:0] s);
        strap_config_level <= s;
        power_down_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        power_down_pin_n <= 1'b1;
        repeat (14) @(posedge pclk);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        chk({video_line_check, packet_check_opt, lock_indicator_pin}, 3'b100);
        presetn <= 1'b1;
        apb(1'b0, `SLMS_OFF_CTRL, 32'h0);
        chk(rd[11:9], 3'b101);
        apb(1'b0, `SLMS_OFF_REVRATE, 32'h0);
        chk(rd, `SLMS_REV_RATE_KBPS);
        apb(1'b0, 12'h00c, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        for (i = 0; i < 8; i++) begin
            des_tunnel <= !i[1];
            pwr_cycle(i[2:0]);
            chk({link_rate_sel, link_coax, link_tunnel}, mode_of(i[2:0]));
            wait_for(1'b1);
            apb(1'b0, `SLMS_OFF_STATUS, 32'h0);
            chk(rd[7:0], {2'b11, i[2:0], 3'b001});
        end
        strap_config_level <= 3'h0;
        repeat (12) @(posedge pclk);
        chk({link_rate_sel, link_coax, link_tunnel}, mode_of(3'h7));
        for (i = 0; i < 6; i++) begin
            w = $random(seed);
            w = {20'h0, 1'b1, w[10:8], 2'b00, w[5:4], w[2], !w[2], 2'b00};
            slow <= w[9];
            des_tunnel <= w[5];
            // No video is ever sent, so every change precedes video and no bandwidth or deskew limit is reached.
            apb(1'b1, `SLMS_OFF_CTRL, w);
            repeat (2) @(posedge pclk);
            chk({link_rate_sel, link_coax, link_tunnel, passthrough_en, e2e_crc_en, long_line_allow,
                 vc_remap_allow, video_line_check, packet_check_opt}, exp_ctrl(w));
            apb(1'b1, `SLMS_OFF_CTRL, w | 32'h40);
            repeat (4) @(posedge pclk);
            chk({link_reset, lock_indicator_pin}, 2'b10);
            apb(1'b1, `SLMS_OFF_CTRL, w);
            wait_for(1'b0);
            wait_for(1'b1);
            apb(1'b1, `SLMS_OFF_CTRL, w | 32'h80);
            wait_for(1'b0);
            wait_for(1'b1);
            apb(1'b1, `SLMS_OFF_CTRL, w & ~32'h800);
            repeat (3) @(posedge pclk);
            apb(1'b0, `SLMS_OFF_STATUS, 32'h0);
            chk({lock_indicator_pin, rd[0]}, 2'b01);
            apb(1'b1, `SLMS_OFF_CTRL, w | {28'h0, i[0], i[0], 2'b00});
            repeat (2) @(posedge pclk);
            chk({link_rate_sel, error_out_pin_n}, {w[3:2], !i[0]});
            apb(1'b1, `SLMS_OFF_STATUS, 32'h4);
            repeat (2) @(posedge pclk);
            chk(error_out_pin_n, 1'b1);
        end
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
